// ==== hdl/fe_pkg.sv ====
package fe_pkg;

   typedef enum logic [2:0] {ST_PD, ST_PG, ST_RX, ST_TX, ST_UF} fe_state_e;
   typedef enum logic [2:0] {HS_IDLE, HS_LEAD, HS_HIGH, HS_LOW, HS_TAIL} spi_phase_e;

   // Clock and settling times
   localparam int CLK_NS        = 10;
   localparam int T_TRX_PD_NS   = 10000;
   localparam int T_PD_PG_NS    = 17500;
   localparam int T_PG_TRX_NS   = 10500;
   localparam int T_TRX_PG_NS   = 3000;
   localparam int T_PG_PD_NS    = 10000;
   localparam int CNT_W         = 11;
   localparam logic [CNT_W-1:0] C_TRX_PD = CNT_W'(T_TRX_PD_NS / CLK_NS);
   localparam logic [CNT_W-1:0] C_PD_PG  = CNT_W'(T_PD_PG_NS / CLK_NS);
   localparam logic [CNT_W-1:0] C_PG_TRX = CNT_W'(T_PG_TRX_NS / CLK_NS);
   localparam logic [CNT_W-1:0] C_TRX_PG = CNT_W'(T_TRX_PG_NS / CLK_NS);
   localparam logic [CNT_W-1:0] C_PG_PD  = CNT_W'(T_PG_PD_NS / CLK_NS);
   localparam logic [CNT_W-1:0] C_ZERO   = 11'h000;

   // Serial link framing
   localparam int SCK_PERIOD_NS = 160;
   localparam logic [3:0] SCK_HALF = 4'(SCK_PERIOD_NS / CLK_NS / 2);
   localparam logic [4:0] BITS_HDR   = 5'h08;
   localparam logic [4:0] BITS_FRAME = 5'h10;
   localparam logic [4:0] BITS_LAST  = 5'h0f;
   localparam logic [1:0] CMD_RD = 2'h2;
   localparam logic [1:0] CMD_WR = 2'h3;

   // Device register addresses
   localparam logic [5:0] ADDR_TXC = 6'h00;
   localparam logic [5:0] ADDR_RXC = 6'h01;
   localparam logic [5:0] ADDR_FA  = 6'h02;
   localparam logic [5:0] ADDR_FB  = 6'h03;

   // Device register fields and reset values
   localparam int GAIN_W      = 5;
   localparam int TXC_TX_EN   = 0;
   localparam int TXC_MODE    = 1;
   localparam int TXC_GAIN_LO = 2;
   localparam int RXC_RX_EN   = 0;
   localparam int RXC_UNLOCK  = 1;
   localparam int RXC_KEY_LO  = 4;
   localparam logic [3:0] KEY_ENTER = 4'h5;
   localparam int FUSE_SRC    = 7;
   localparam int FUSE_BURN   = 5;
   localparam logic [7:0] REG_RST  = 8'h00;
   localparam logic [5:0] FUSE_RST = 6'h00;

   // Burn wait kept by the host
   localparam int BURN_WAIT_NS = 500000;

   // Host register offsets and fields
   localparam logic [11:0] OFF_PINS = 12'h000;
   localparam logic [11:0] OFF_CMD  = 12'h004;
   localparam logic [11:0] OFF_STAT = 12'h008;
   localparam int PIN_PWR  = 0;
   localparam int PIN_RX   = 1;
   localparam int PIN_TX   = 2;
   localparam int PIN_MODE = 3;
   localparam int PIN_ANT  = 4;
   localparam int STAT_BUSY = 0;
   localparam int STAT_BURN = 1;
   localparam int STAT_RD_LO = 8;

   // Device pin synchroniser slots
   localparam int SY_PWR  = 0;
   localparam int SY_RX   = 1;
   localparam int SY_TX   = 2;
   localparam int SY_MODE = 3;
   localparam int SY_ANT  = 4;
   localparam int SY_SCK  = 5;
   localparam int SY_CSN  = 6;
   localparam int SY_MOSI = 7;

endpackage

// ==== hdl/fe_link_if.sv ====
`timescale 1ns/1ns
interface fe_link_if;
   logic power_off_control;
   logic rx_request;
   logic tx_request;
   logic mode_pin;
   logic antenna_choice;
   logic sck;
   logic csn;
   logic mosi;
   logic miso;

   modport dev (
      input  power_off_control,
      input  rx_request,
      input  tx_request,
      input  mode_pin,
      input  antenna_choice,
      input  sck,
      input  csn,
      input  mosi,
      output miso
   );

   modport host (
      output power_off_control,
      output rx_request,
      output tx_request,
      output mode_pin,
      output antenna_choice,
      output sck,
      output csn,
      output mosi,
      input  miso
   );
endinterface

// ==== hdl/fe_device.sv ====
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
// Summary of operation
// - Power control low holds power-down, paths off
// - Power control high enters program, registers reset
// - Requests from pins or control register fields
// - Receive state enables low noise amp, receive
// - Transmit state enables power amp, transmit
// - Host never requests two states at once
// - Fuse state entered from program after unlock
// - Non-radio states isolate both antenna ports
// - Radio states connect port by antenna choice
// - Serial changes timed from sixteenth falling edge
// - Power control settling: 10, 17.5, 10 us
// - Request settling: 10.5 us on, 3 us off
// - Host keeps gain steady while transmitting
// - Mode change in program reloads gain preset
// - Mode set loads preset B, clear A
// - Preset source picks factory or user value
// - Serial gain write in program overrides preset
// - Transmit by same write or later pin
// - Host unlocks, then writes enter key
// - Host writes B, A, burn, waits 0.5 ms
// - Host cycles power control after burn
// - Fuse state reads back burned fuse contents
// - Fuse registers reachable only in fuse state
module fe_device #(
   parameter logic [4:0] PRESET_A_FACTORY = 5'h0a,
   parameter logic [4:0] PRESET_B_FACTORY = 5'h14
) (
   // Clock and reset
   input  logic                    pclk,
   input  logic                    presetn,
   // Link to host
   fe_link_if.dev                  link,
   // Front-end controls
   output fe_pkg::fe_state_e       state,
   output logic                    settled,
   output logic                    lna_en,
   output logic                    rx_path_en,
   output logic                    pa_en,
   output logic                    tx_path_en,
   output logic                    antenna_port_one,
   output logic                    antenna_port_two,
   output logic [fe_pkg::GAIN_W-1:0] tx_gain
);

   typedef struct packed {
      logic [7:0]               s1;
      logic [7:0]               s2;
      logic                     sck_d;
      logic                     mode_d;
      fe_pkg::fe_state_e        st;
      logic [fe_pkg::CNT_W-1:0] cnt;
      logic [15:0]              shin;
      logic [4:0]               bits;
      logic [7:0]               miso_sh;
      logic [7:0]               tx_control_reg;
      logic [7:0]               rx_control_reg;
      logic [7:0]               fuse_prog_a_reg;
      logic [7:0]               fuse_prog_b_reg;
      logic [fe_pkg::GAIN_W-1:0] gain;
      logic [5:0]               user_fuse_area_a;
      logic [5:0]               user_fuse_area_b;
   } dev_s;

   dev_s r_r;
   dev_s r_nxt;

   function automatic logic [fe_pkg::GAIN_W-1:0] preset(input logic m, input logic [5:0] ua, input logic [5:0] ub);
      logic [fe_pkg::GAIN_W-1:0] g;
      if (m) begin
         g = ub[5] ? ub[fe_pkg::GAIN_W-1:0] : PRESET_B_FACTORY;
      end else begin
         g = ua[5] ? ua[fe_pkg::GAIN_W-1:0] : PRESET_A_FACTORY;
      end
      return g;
   endfunction

   function automatic logic reachable(input logic [5:0] a, input fe_pkg::fe_state_e s);
      logic ok;
      ok = 1'b0;
      if (a == fe_pkg::ADDR_TXC || a == fe_pkg::ADDR_RXC) begin
         ok = (s != fe_pkg::ST_PD);
      end else if (a == fe_pkg::ADDR_FA || a == fe_pkg::ADDR_FB) begin
         ok = (s == fe_pkg::ST_UF);
      end
      return ok;
   endfunction

   logic        pwr;
   logic        rx_req;
   logic        tx_req;
   logic        eff_mode;
   logic        sck_rise;
   logic        sck_fall;
   logic        uf_go;
   logic [1:0]  cmd;
   logic [5:0]  addr;
   logic [7:0]  data;
   logic [7:0]  rd_val;

   always_comb begin
      r_nxt = r_r;
      r_nxt.s1 = {link.mosi, link.csn, link.sck, link.antenna_choice,
                  link.mode_pin, link.tx_request, link.rx_request, link.power_off_control};
      r_nxt.s2 = r_r.s1;
      r_nxt.sck_d = r_r.s2[fe_pkg::SY_SCK];
      pwr = r_r.s2[fe_pkg::SY_PWR];
      rx_req = r_r.s2[fe_pkg::SY_RX] | r_r.rx_control_reg[fe_pkg::RXC_RX_EN];
      tx_req = r_r.s2[fe_pkg::SY_TX] | r_r.tx_control_reg[fe_pkg::TXC_TX_EN];
      eff_mode = r_r.s2[fe_pkg::SY_MODE] | r_r.tx_control_reg[fe_pkg::TXC_MODE];
      r_nxt.mode_d = eff_mode;
      sck_rise = r_r.s2[fe_pkg::SY_SCK] & ~r_r.sck_d;
      sck_fall = ~r_r.s2[fe_pkg::SY_SCK] & r_r.sck_d;
      uf_go = 1'b0;
      cmd = r_r.shin[15:14];
      addr = r_r.shin[13:8];
      data = r_r.shin[7:0];
      rd_val = fe_pkg::REG_RST;
      if (reachable(r_r.shin[5:0], r_r.st)) begin
         if (r_r.shin[5:0] == fe_pkg::ADDR_TXC) begin
            rd_val = r_r.tx_control_reg;
         end else if (r_r.shin[5:0] == fe_pkg::ADDR_RXC) begin
            rd_val = r_r.rx_control_reg;
         end else if (r_r.shin[5:0] == fe_pkg::ADDR_FA) begin
            rd_val = r_r.fuse_prog_a_reg;
         end else begin
            rd_val = r_r.fuse_prog_b_reg;
         end
      end

      if (r_r.cnt != fe_pkg::C_ZERO) begin
         r_nxt.cnt = r_r.cnt - 11'h001;
      end

      // Preset reload on any mode change in program state
      if (r_r.st == fe_pkg::ST_PG && eff_mode != r_r.mode_d) begin
         r_nxt.gain = preset(eff_mode, r_r.user_fuse_area_a, r_r.user_fuse_area_b);
      end

      // Serial slave
      if (r_r.s2[fe_pkg::SY_CSN]) begin
         r_nxt.bits = 5'h00;
         r_nxt.miso_sh = fe_pkg::REG_RST;
      end else if (sck_rise) begin
         r_nxt.shin = {r_r.shin[14:0], r_r.s2[fe_pkg::SY_MOSI]};
         r_nxt.bits = r_r.bits + 5'h01;
      end else if (sck_fall) begin
         if (r_r.bits == fe_pkg::BITS_HDR) begin
            r_nxt.miso_sh = r_r.shin[7] ? rd_val : fe_pkg::REG_RST;
         end else if (r_r.bits > fe_pkg::BITS_HDR) begin
            r_nxt.miso_sh = {r_r.miso_sh[6:0], 1'b0};
         end
         if (r_r.bits == fe_pkg::BITS_FRAME && cmd == fe_pkg::CMD_WR && reachable(addr, r_r.st)) begin
            if (addr == fe_pkg::ADDR_TXC) begin
               r_nxt.tx_control_reg = data;
               if (r_r.st == fe_pkg::ST_PG) begin
                  r_nxt.gain = data[fe_pkg::TXC_GAIN_LO +: fe_pkg::GAIN_W];
               end
            end else if (addr == fe_pkg::ADDR_RXC) begin
               r_nxt.rx_control_reg = data;
               uf_go = (r_r.st == fe_pkg::ST_PG) && r_r.rx_control_reg[fe_pkg::RXC_UNLOCK] &&
                       (data[fe_pkg::RXC_KEY_LO +: 4] == fe_pkg::KEY_ENTER);
            end else if (addr == fe_pkg::ADDR_FA) begin
               r_nxt.fuse_prog_a_reg = data & ~(8'h01 << fe_pkg::FUSE_BURN);
               if (data[fe_pkg::FUSE_BURN]) begin
                  r_nxt.user_fuse_area_a = {data[fe_pkg::FUSE_SRC], data[fe_pkg::GAIN_W-1:0]};
                  r_nxt.user_fuse_area_b = {r_r.fuse_prog_b_reg[fe_pkg::FUSE_SRC],
                                            r_r.fuse_prog_b_reg[fe_pkg::GAIN_W-1:0]};
               end
            end else begin
               r_nxt.fuse_prog_b_reg = data;
            end
         end
      end

      // Operating state machine
      case (r_r.st)
         fe_pkg::ST_PD: begin
            r_nxt.tx_control_reg = fe_pkg::REG_RST;
            r_nxt.rx_control_reg = fe_pkg::REG_RST;
            r_nxt.fuse_prog_a_reg = fe_pkg::REG_RST;
            r_nxt.fuse_prog_b_reg = fe_pkg::REG_RST;
            r_nxt.gain = preset(r_r.s2[fe_pkg::SY_MODE], r_r.user_fuse_area_a, r_r.user_fuse_area_b);
            if (pwr) begin
               r_nxt.st = fe_pkg::ST_PG;
               r_nxt.cnt = fe_pkg::C_PD_PG;
            end
         end
         fe_pkg::ST_PG: begin
            if (!pwr) begin
               r_nxt.st = fe_pkg::ST_PD;
               r_nxt.cnt = fe_pkg::C_PG_PD;
            end else if (uf_go) begin
               r_nxt.st = fe_pkg::ST_UF;
               r_nxt.cnt = fe_pkg::C_ZERO;
               r_nxt.fuse_prog_a_reg = {r_r.user_fuse_area_a[5], 2'h0, r_r.user_fuse_area_a[4:0]};
               r_nxt.fuse_prog_b_reg = {r_r.user_fuse_area_b[5], 2'h0, r_r.user_fuse_area_b[4:0]};
            end else if (r_r.cnt == fe_pkg::C_ZERO && rx_req) begin
               r_nxt.st = fe_pkg::ST_RX;
               r_nxt.cnt = fe_pkg::C_PG_TRX;
            end else if (r_r.cnt == fe_pkg::C_ZERO && tx_req) begin
               r_nxt.st = fe_pkg::ST_TX;
               r_nxt.cnt = fe_pkg::C_PG_TRX;
            end
         end
         fe_pkg::ST_RX: begin
            if (!pwr) begin
               r_nxt.st = fe_pkg::ST_PD;
               r_nxt.cnt = fe_pkg::C_TRX_PD;
            end else if (!rx_req) begin
               r_nxt.st = fe_pkg::ST_PG;
               r_nxt.cnt = fe_pkg::C_TRX_PG;
            end
         end
         fe_pkg::ST_TX: begin
            if (!pwr) begin
               r_nxt.st = fe_pkg::ST_PD;
               r_nxt.cnt = fe_pkg::C_TRX_PD;
            end else if (!tx_req) begin
               r_nxt.st = fe_pkg::ST_PG;
               r_nxt.cnt = fe_pkg::C_TRX_PG;
            end
         end
         default: begin
            if (!pwr) begin
               r_nxt.st = fe_pkg::ST_PD;
               r_nxt.cnt = fe_pkg::C_PG_PD;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_r <= '0;
      end else begin
         r_r <= r_nxt;
      end
   end

   // Decoded controls
   assign state = r_r.st;
   assign settled = (r_r.cnt == fe_pkg::C_ZERO);
   assign lna_en = settled && r_r.st == fe_pkg::ST_RX;
   assign rx_path_en = settled && r_r.st == fe_pkg::ST_RX;
   assign pa_en = settled && r_r.st == fe_pkg::ST_TX;
   assign tx_path_en = settled && r_r.st == fe_pkg::ST_TX;
   assign antenna_port_one = (lna_en || pa_en) && !r_r.s2[fe_pkg::SY_ANT];
   assign antenna_port_two = (lna_en || pa_en) && r_r.s2[fe_pkg::SY_ANT];
   assign tx_gain = r_r.gain;
   assign link.miso = r_r.miso_sh[7];

endmodule

// ==== hdl/fe_host.sv ====
`timescale 1ns/1ns
module fe_host #(
   parameter int BURN_WAIT_CYC = fe_pkg::BURN_WAIT_NS / fe_pkg::CLK_NS
) (
   // Clock and reset
   input  logic        pclk,
   input  logic        presetn,
   // APB slave
   input  logic [11:0] paddr,
   input  logic        psel,
   input  logic        penable,
   input  logic        pwrite,
   input  logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic        pready,
   output logic        pslverr,
   // Link to device
   fe_link_if.host     link
);

   typedef struct packed {
      logic [4:0]         pins;
      logic [15:0]        frame;
      logic [15:0]        shout;
      logic [7:0]         rd;
      logic               m1;
      logic               m2;
      fe_pkg::spi_phase_e ph;
      logic [3:0]         div;
      logic [4:0]         bits;
      logic               sck;
      logic               csn;
      logic               mosi;
      logic [15:0]        burn;
      logic [31:0]        prdata;
      logic               err;
   } host_s;

   host_s r_r;
   host_s r_nxt;

   logic       setup;
   logic       access;
   logic       busy;
   logic       burn_frame;
   logic       div_done;
   logic [4:0] np;

   always_comb begin
      r_nxt = r_r;
      r_nxt.m1 = link.miso;
      r_nxt.m2 = r_r.m1;
      setup = psel && !penable;
      access = psel && penable;
      busy = (r_r.ph != fe_pkg::HS_IDLE) || (r_r.burn != 16'h0000);
      np = pwdata[4:0];
      burn_frame = (r_r.frame[15:14] == fe_pkg::CMD_WR) && (r_r.frame[13:8] == fe_pkg::ADDR_FA) &&
                   r_r.frame[fe_pkg::FUSE_BURN];
      div_done = (r_r.div == 4'h0);
      if (!div_done) begin
         r_nxt.div = r_r.div - 4'h1;
      end
      if (r_r.burn != 16'h0000) begin
         r_nxt.burn = r_r.burn - 16'h0001;
      end

      // Register read data and error latched in setup
      if (setup) begin
         r_nxt.prdata = 32'h0000_0000;
         r_nxt.err = 1'b0;
         if (paddr == fe_pkg::OFF_PINS) begin
            r_nxt.prdata = {27'h000_0000, r_r.pins};
            r_nxt.err = pwrite && np[fe_pkg::PIN_RX] && np[fe_pkg::PIN_TX];
         end else if (paddr == fe_pkg::OFF_CMD) begin
            r_nxt.prdata = {16'h0000, r_r.frame};
            r_nxt.err = pwrite && busy;
         end else if (paddr == fe_pkg::OFF_STAT) begin
            r_nxt.prdata = {16'h0000, r_r.rd, 6'h00, r_r.burn != 16'h0000, r_r.ph != fe_pkg::HS_IDLE};
         end else begin
            r_nxt.err = 1'b1;
         end
      end

      // Register writes in access phase
      if (access && pwrite && !r_r.err) begin
         if (paddr == fe_pkg::OFF_PINS) begin
            r_nxt.pins = np;
            if (r_r.pins[fe_pkg::PIN_TX] && np[fe_pkg::PIN_TX]) begin
               r_nxt.pins[fe_pkg::PIN_MODE] = r_r.pins[fe_pkg::PIN_MODE];
            end
         end else if (paddr == fe_pkg::OFF_CMD) begin
            r_nxt.frame = pwdata[15:0];
            r_nxt.shout = pwdata[15:0];
            r_nxt.mosi = pwdata[15];
            r_nxt.csn = 1'b0;
            r_nxt.bits = 5'h00;
            r_nxt.div = fe_pkg::SCK_HALF - 4'h1;
            r_nxt.ph = fe_pkg::HS_LEAD;
         end
      end

      // Serial master, mode 0
      case (r_r.ph)
         fe_pkg::HS_LEAD, fe_pkg::HS_LOW: begin
            if (div_done) begin
               r_nxt.sck = 1'b1;
               r_nxt.rd = {r_r.rd[6:0], r_r.m2};
               r_nxt.div = fe_pkg::SCK_HALF - 4'h1;
               r_nxt.ph = fe_pkg::HS_HIGH;
            end
         end
         fe_pkg::HS_HIGH: begin
            if (div_done) begin
               r_nxt.sck = 1'b0;
               r_nxt.bits = r_r.bits + 5'h01;
               r_nxt.div = fe_pkg::SCK_HALF - 4'h1;
               if (r_r.bits == fe_pkg::BITS_LAST) begin
                  r_nxt.ph = fe_pkg::HS_TAIL;
               end else begin
                  r_nxt.shout = {r_r.shout[14:0], 1'b0};
                  r_nxt.mosi = r_r.shout[14];
                  r_nxt.ph = fe_pkg::HS_LOW;
               end
            end
         end
         fe_pkg::HS_TAIL: begin
            if (div_done) begin
               r_nxt.csn = 1'b1;
               r_nxt.ph = fe_pkg::HS_IDLE;
               if (burn_frame) begin
                  r_nxt.burn = 16'(BURN_WAIT_CYC);
               end
            end
         end
         default: begin
            r_nxt.sck = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_r <= '0;
         r_r.csn <= 1'b1;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign prdata = r_r.prdata;
   assign pready = 1'b1;
   assign pslverr = r_r.err && psel && penable;
   assign link.power_off_control = r_r.pins[fe_pkg::PIN_PWR];
   assign link.rx_request = r_r.pins[fe_pkg::PIN_RX];
   assign link.tx_request = r_r.pins[fe_pkg::PIN_TX];
   assign link.mode_pin = r_r.pins[fe_pkg::PIN_MODE];
   assign link.antenna_choice = r_r.pins[fe_pkg::PIN_ANT];
   assign link.sck = r_r.sck;
   assign link.csn = r_r.csn;
   assign link.mosi = r_r.mosi;

endmodule

// ==== tb/fe_properties.sv ====
`timescale 1ns/1ns
module fe_properties (
   // Clock and reset
   input logic              pclk,
   input logic              presetn,
   // Link pins
   input logic              power_off_control,
   input logic              rx_request,
   input logic              tx_request,
   input logic              antenna_choice,
   input logic              csn,
   // Device outputs
   input fe_pkg::fe_state_e state,
   input logic              settled,
   input logic              lna_en,
   input logic              rx_path_en,
   input logic              pa_en,
   input logic              tx_path_en,
   input logic              antenna_port_one,
   input logic              antenna_port_two
);
   logic pd_s;
   logic pg_s;
   logic rx_s;
   logic tx_s;
   assign pd_s = (state == fe_pkg::ST_PD);
   assign pg_s = (state == fe_pkg::ST_PG);
   assign rx_s = (state == fe_pkg::ST_RX);
   assign tx_s = (state == fe_pkg::ST_TX);

   fe_pkg::fe_state_e prev_st;
   fe_pkg::fe_state_e from_st;
   fe_pkg::fe_state_e from_now;
   logic [11:0]       cyc_r;
   logic [11:0]       cyc_now;
   assign from_now = (state != prev_st) ? prev_st : from_st;
   assign cyc_now = (state != prev_st) ? 12'h000 : cyc_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_st <= fe_pkg::ST_PD;
         from_st <= fe_pkg::ST_PD;
         cyc_r   <= 12'h000;
      end else begin
         prev_st <= state;
         from_st <= from_now;
         cyc_r   <= cyc_now + 12'(!settled);
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   pd_hold_a: assert property (!power_off_control [*6] |-> pd_s)
      else $error("power-down not held");
   pwr_up_a: assert property (pd_s && $rose(power_off_control) ##1 power_off_control [*5] |-> pg_s)
      else $error("no program state after power-up");
   rx_paths_a: assert property (lna_en == (rx_s && settled) && rx_path_en == (rx_s && settled))
      else $error("receive path enables wrong");
   tx_paths_a: assert property (pa_en == (tx_s && settled) && tx_path_en == (tx_s && settled))
      else $error("transmit path enables wrong");
   ant_iso_a: assert property (!((rx_s || tx_s) && settled) |-> !antenna_port_one && !antenna_port_two)
      else $error("antenna not isolated");
   ant_pick_a: assert property ($stable(antenna_choice) [*4] ##0 ((rx_s || tx_s) && settled)
      |-> antenna_port_one == !antenna_choice && antenna_port_two == antenna_choice)
      else $error("wrong antenna port");
   one_req_a: assert property (!(rx_request && tx_request))
      else $error("two states requested");
   pd_pg_time_a: assert property ((pg_s && $past(pd_s) |-> !settled) and
      (pg_s && from_now == fe_pkg::ST_PD |-> cyc_now <= fe_pkg::C_PD_PG))
      else $error("power-up settle wrong");
   pd_time_a: assert property ((pd_s && !$past(pd_s) |-> !settled) and
      (pd_s && from_now != fe_pkg::ST_PD |-> cyc_now <= fe_pkg::C_TRX_PD))
      else $error("power-down settle wrong");
   trx_on_time_a: assert property (((rx_s || tx_s) && $past(pg_s) |-> !settled) and
      ((rx_s || tx_s) && from_now == fe_pkg::ST_PG |-> cyc_now <= fe_pkg::C_PG_TRX))
      else $error("radio settle wrong");
   trx_off_time_a: assert property (pg_s && ($past(rx_s) || $past(tx_s)) |-> !settled ##[1:301] settled)
      else $error("radio off settle wrong");

   cover property (tx_s && settled);
   cover property (rx_s && settled && antenna_port_two);
   cover property (state == fe_pkg::ST_UF);
   cover property ($fell(csn));
endmodule

// ==== tb/rf_frontend_state_control_tb.sv ====
`timescale 1ns/1ns
module rf_frontend_state_control_tb;
   typedef struct {logic [31:0] v; logic [31:0] m; logic e;} exp_s;
   localparam logic [4:0] FA = 5'h0b;
   localparam logic [4:0] FB = 5'h16;
   logic              pclk;
   logic              presetn;
   logic [11:0]       paddr;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   fe_pkg::fe_state_e st;
   logic              settled;
   logic [5:0]        paths;
   logic [4:0]        tx_gain;
   logic [4:0]        g;
   logic [31:0]       r;
   integer            seed;
   int                fail_count;
   int                samples_checked;
   exp_s              exp_q[$];
   exp_s              mx;

   fe_link_if link ();
   fe_device #(.PRESET_A_FACTORY(FA), .PRESET_B_FACTORY(FB)) i_fe_device (.pclk(pclk), .presetn(presetn),
      .link(link), .state(st), .settled(settled), .lna_en(paths[5]), .rx_path_en(paths[4]), .pa_en(paths[3]),
      .tx_path_en(paths[2]), .antenna_port_one(paths[1]), .antenna_port_two(paths[0]), .tx_gain(tx_gain));
   fe_host #(.BURN_WAIT_CYC(20)) i_fe_host (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link));
   fe_properties i_fe_properties (.pclk(pclk), .presetn(presetn),
      .power_off_control(link.power_off_control), .rx_request(link.rx_request), .tx_request(link.tx_request),
      .antenna_choice(link.antenna_choice), .csn(link.csn), .state(st), .settled(settled),
      .lna_en(paths[5]), .rx_path_en(paths[4]), .pa_en(paths[3]), .tx_path_en(paths[2]),
      .antenna_port_one(paths[1]), .antenna_port_two(paths[0]));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
      samples_checked++;
      if (s !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask

   // Bus answer watcher
   always @(negedge pclk) begin
      if (psel && penable && pready === 1'b1) begin
         mx = exp_q.pop_front();
         cmp("prdata", mx.v & mx.m, prdata & mx.m);
         cmp("pslverr", {31'h0, mx.e}, {31'h0, pslverr});
      end
   end

   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [31:0] v,
                      input logic [31:0] m, input logic e);
      logic ok;
      exp_q.push_back('{v, m, e});
      @(posedge pclk);
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      psel    <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         r  = prdata;
         ok = pready;
      end while (ok !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic pins(input logic [4:0] p, input logic e);
      apb(fe_pkg::OFF_PINS, 1'b1, {27'h0, p}, 32'h0, 32'h0, e);
   endtask

   task automatic spi(input logic [1:0] c, input logic [5:0] a, input logic [7:0] d);
      int n;
      apb(fe_pkg::OFF_CMD, 1'b1, {16'h0, c, a, d}, 32'h0, 32'h0, 1'b0);
      n = 0;
      r = 32'h3;
      while (r[1:0] !== 2'b00 && n < 200) begin
         apb(fe_pkg::OFF_STAT, 1'b0, 32'h0, 32'h0, 32'h0, 1'b0);
         n++;
      end
      cmp("busy", 32'h0, {30'h0, r[1:0]});
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      spi(fe_pkg::CMD_WR, a, d);
   endtask

   task automatic rd(input logic [5:0] a, input logic [7:0] b);
      spi(fe_pkg::CMD_RD, a, 8'h00);
      apb(fe_pkg::OFF_STAT, 1'b0, 32'h0, {16'h0, b, 8'h0}, 32'h0000_ff00, 1'b0);
   endtask

   task automatic wait_state(input fe_pkg::fe_state_e s, input logic [5:0] p);
      int n;
      n = 0;
      while (!(st === s && settled === 1'b1) && n < 4000) begin
         @(negedge pclk);
         n++;
      end
      cmp("state", 32'(s), 32'(st));
      cmp("paths", 32'(p), 32'(paths));
   endtask

   task automatic gain(input logic [4:0] v);
      repeat (8) @(negedge pclk);
      cmp("tx_gain", 32'(v), 32'(tx_gain));
   endtask

   task automatic complete_run;
      if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      #800000;
      fail_count++;
      complete_run();
   end

   initial begin
      seed = 32'h2dfeed9f;
      fail_count = 0;
      samples_checked = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      wait_state(fe_pkg::ST_PD, 6'h00);
      pins(5'h01, 1'b0);
      wait_state(fe_pkg::ST_PG, 6'h00);
      rd(fe_pkg::ADDR_TXC, 8'h00);
      pins(5'h09, 1'b0);
      gain(FB);
      pins(5'h01, 1'b0);
      gain(FA);
      pins(5'h07, 1'b1);
      wr(fe_pkg::ADDR_RXC, 8'h50);
      wait_state(fe_pkg::ST_PG, 6'h00);
      rd(fe_pkg::ADDR_FA, 8'h00);
      g = 5'($random(seed));
      wr(fe_pkg::ADDR_TXC, {1'b0, g, 2'b01});
      wait_state(fe_pkg::ST_TX, 6'b001110);
      gain(g);
      wr(fe_pkg::ADDR_TXC, {1'b0, g, 2'b00});
      wait_state(fe_pkg::ST_PG, 6'h00);
      for (int i = 0; i < 2; i++) begin
         pins({i[0], 4'b0011}, 1'b0);
         wait_state(fe_pkg::ST_RX, {4'b1100, !i[0], i[0]});
         pins(5'h01, 1'b0);
         wait_state(fe_pkg::ST_PG, 6'h00);
      end
      pins(5'h15, 1'b0);
      wait_state(fe_pkg::ST_TX, 6'b001101);
      gain(g);
      pins(5'h00, 1'b0);
      wait_state(fe_pkg::ST_PD, 6'h00);
      pins(5'h01, 1'b0);
      wait_state(fe_pkg::ST_PG, 6'h00);
      apb(12'h00c, 1'b0, 32'h0, 32'h0, 32'hffff_ffff, 1'b1);
      for (int k = 0; k < 2; k++) begin
         wr(fe_pkg::ADDR_RXC, 8'h02);
         wr(fe_pkg::ADDR_RXC, 8'h52);
         wait_state(fe_pkg::ST_UF, 6'h00);
         if (k == 0) begin
            wr(fe_pkg::ADDR_FB, 8'h83);
            wr(fe_pkg::ADDR_FA, 8'ha7);
            pins(5'h00, 1'b0);
            wait_state(fe_pkg::ST_PD, 6'h00);
            pins(5'h01, 1'b0);
            wait_state(fe_pkg::ST_PG, 6'h00);
            gain(5'h07);
            pins(5'h09, 1'b0);
            gain(5'h03);
            pins(5'h01, 1'b0);
         end
      end
      rd(fe_pkg::ADDR_FA, 8'h87);
      rd(fe_pkg::ADDR_FB, 8'h83);
      complete_run();
   end
endmodule
